/* core/bbar_bridge.sv */
// Bit-band alias remapping bridge between the core data bus and memory/peripheral bus
//
// Overview of operation
// - SRAM alias word maps to one bit
// - Peripheral alias word maps to one bit
// - Bit-band spaces at bottom 1 MB
// - Alias offset is byte*32 plus bit*4
// - Bit number 0-7 from alias address
// - Underlying access keeps the alias access size
// - Alias write is read-modify-write of one bit
// - SRAM alias fetches pass through unremapped
// - Peripheral alias fetches are rejected
// - Write data bit 0 sets or clears
// - Write data bits 31:1 are ignored
// - Alias read returns zero or one
// - Direct SRAM bit-band accesses pass through
// - Direct peripheral bit-band accesses pass through
// - Little-endian byte lanes
// - Peripheral alias covers peripheral bit-band space
`timescale 1ns/1ps
module bbar_bridge (
  // Clock and reset
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST,
  // Upstream request from the core
  input  wire logic                   I_REQ_VALID,
  input  wire bbar_pkg::bbar_req_type I_REQ,
  output logic                        O_REQ_READY,
  // Upstream response
  output logic                        O_RSP_VALID,
  output bbar_pkg::bbar_rsp_type      O_RSP,
  // Downstream memory and peripheral bus
  output logic                        O_MEM_VALID,
  output bbar_pkg::bbar_mem_type      O_MEM,
  input  wire logic                   I_MEM_READY,
  input  wire logic                   I_MEM_RVALID,
  input  wire logic [31:0]            I_MEM_RDATA
);
  import bbar_pkg::*;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  bbar_state_type state;
  bbar_state_type next_state;
  bbar_req_type   cur_req;
  bbar_req_type   next_cur_req;
  bbar_map_type   cur_map;
  bbar_map_type   next_cur_map;
  bbar_mem_type   mem;
  bbar_mem_type   next_mem;
  logic           mem_valid;
  logic           next_mem_valid;
  bbar_rsp_type   rsp;
  bbar_rsp_type   next_rsp;
  logic [31:0]    rd_hold;
  logic [31:0]    next_rd_hold;
  bbar_map_type   map;
  logic           sel_bit;
  logic           rmw;

  // ***************************************************************
  // Address decode
  // ***************************************************************
  bbar_remap u_remap (
    .i_req (I_REQ),
    .o_map (map)
  );

  assign sel_bit = I_MEM_RDATA[cur_map.pos];
  assign rmw     = cur_map.remap && cur_req.write;

  // ***************************************************************
  // Transfer sequencer
  // ***************************************************************
  always_comb begin
    next_state     = state;
    next_cur_req   = cur_req;
    next_cur_map   = cur_map;
    next_mem       = mem;
    next_mem_valid = mem_valid;
    next_rsp       = rsp;
    next_rd_hold   = rd_hold;
    case (state)
      S_IDLE: begin
        if (I_REQ_VALID) begin
          next_cur_req = I_REQ;
          next_cur_map = map;
          if (map.err) begin
            // Fetch from peripheral alias never reaches the bus
            next_rsp   = '{rdata: DATA_RESET, err: 1'b1};
            next_state = S_RESP;
          end else begin
            next_mem_valid = 1'b1;
            next_mem.addr  = map.addr;
            next_mem.size  = map.size;
            // An alias write starts with the read half
            next_mem.write = I_REQ.write && !map.remap;
            next_mem.wdata = map.remap ? DATA_RESET : I_REQ.wdata;
            next_mem.lock  = map.remap && I_REQ.write;
            next_state     = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        if (I_MEM_READY) begin
          next_mem_valid = 1'b0;
          next_state     = S_WAIT;
        end
      end
      S_WAIT: begin
        if (I_MEM_RVALID) begin
          if (rmw) begin
            next_rd_hold   = I_MEM_RDATA;
            // Only bit 0 of the alias data decides the new bit value
            next_mem.wdata = bbar_put_bit(I_MEM_RDATA, cur_map.pos,
                                          cur_req.wdata[0]);
            next_mem.write = 1'b1;
            next_mem_valid = 1'b1;
            next_state     = S_WR_ISSUE;
          end else begin
            next_rsp.err = 1'b0;
            if (!cur_map.remap) begin
              next_rsp.rdata = I_MEM_RDATA;
            end else if (sel_bit) begin
              next_rsp.rdata = ALIAS_ONE;
            end else begin
              next_rsp.rdata = DATA_RESET;
            end
            next_state = S_RESP;
          end
        end
      end
      S_WR_ISSUE: begin
        if (I_MEM_READY) begin
          next_mem_valid = 1'b0;
          next_state     = S_WR_WAIT;
        end
      end
      S_WR_WAIT: begin
        if (I_MEM_RVALID) begin
          // Lock falls only once the write half has completed
          next_mem.lock = 1'b0;
          next_rsp      = '{rdata: DATA_RESET, err: 1'b0};
          next_state    = S_RESP;
        end
      end
      S_RESP: begin
        next_mem.lock = 1'b0;
        next_state    = S_IDLE;
      end
      default: begin
        next_mem_valid = 1'b0;
        next_state     = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state     <= S_IDLE;
      cur_req   <= '0;
      cur_map   <= '0;
      mem       <= '0;
      mem_valid <= 1'b0;
      rsp       <= '0;
      rd_hold   <= DATA_RESET;
    end else begin
      state     <= next_state;
      cur_req   <= next_cur_req;
      cur_map   <= next_cur_map;
      mem       <= next_mem;
      mem_valid <= next_mem_valid;
      rsp       <= next_rsp;
      rd_hold   <= next_rd_hold;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign O_REQ_READY = (state == S_IDLE);
  assign O_RSP_VALID = (state == S_RESP);
  assign O_RSP       = rsp;
  assign O_MEM_VALID = mem_valid;
  assign O_MEM       = mem;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  logic [31:0] chk_tbyte;
  logic [31:0] chk_base_bb;
  logic [31:0] chk_base_alias;
  logic [31:0] chk_mask;
  logic        acc_sram_fetch;
  logic        chk_rd_bit;

  assign chk_tbyte      = {O_MEM.addr[31:2], cur_map.pos[4:3]};
  assign chk_base_bb    = (O_MEM.addr[31:28] == SRAM_BB_BASE[31:28]) ? SRAM_BB_BASE
                                                                       : PERI_BB_BASE;
  assign chk_base_alias = (chk_base_bb == SRAM_BB_BASE) ? SRAM_ALIAS_BASE : PERI_ALIAS_BASE;
  assign chk_mask       = 32'h0000_0001 << cur_map.pos;
  assign acc_sram_fetch = I_REQ_VALID && O_REQ_READY && I_REQ.fetch &&
                          ((I_REQ.addr - SRAM_ALIAS_BASE) < ALIAS_SIZE);
  // Bit position straight from the alias word address, independent of the decoder
  assign chk_rd_bit     = I_MEM_RDATA[cur_req.addr[6:2]];

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  property p_alias_addr;
    O_MEM_VALID && cur_map.remap |->
      (bbar_alias_addr(chk_base_alias, 20'(chk_tbyte - chk_base_bb), cur_map.pos[2:0])
       == {cur_req.addr[31:2], 2'h0}) && ((chk_tbyte - chk_base_bb) < BB_SIZE);
  endproperty
  a_alias_addr: assert property (p_alias_addr) else $error("alias address mismatch");

  property p_size;
    O_MEM_VALID |-> O_MEM.size == cur_req.size;
  endproperty
  a_size: assert property (p_size) else $error("downstream size differs");

  property p_wr_bit;
    O_MEM_VALID && O_MEM.write && cur_map.remap |->
      O_MEM.wdata[cur_map.pos] == cur_req.wdata[0];
  endproperty
  a_wr_bit: assert property (p_wr_bit) else $error("alias write bit wrong");

  property p_wr_keep;
    O_MEM_VALID && O_MEM.write && cur_map.remap |->
      (O_MEM.wdata & ~chk_mask) == (rd_hold & ~chk_mask);
  endproperty
  a_wr_keep: assert property (p_wr_keep) else $error("rmw changed other bits");

  property p_lock;
    state == S_WAIT && rmw && I_MEM_RVALID |=> O_MEM.lock && O_MEM_VALID && O_MEM.write;
  endproperty
  a_lock: assert property (p_lock) else $error("write half not locked");

  property p_periph_fetch;
    I_REQ_VALID && O_REQ_READY && map.err |=> O_RSP_VALID && O_RSP.err && !O_MEM_VALID;
  endproperty
  a_periph_fetch: assert property (p_periph_fetch) else $error("fetch not rejected");

  property p_sram_fetch;
    acc_sram_fetch |=> O_MEM_VALID && !cur_map.remap && O_MEM.addr == cur_req.addr;
  endproperty
  a_sram_fetch: assert property (p_sram_fetch) else $error("fetch was remapped");

  property p_rd_value;
    state == S_WAIT && I_MEM_RVALID && cur_map.remap && !cur_req.write |=>
      O_RSP_VALID && O_RSP.rdata == {31'h0, $past(chk_rd_bit)};
  endproperty
  a_rd_value: assert property (p_rd_value) else $error("alias read value wrong");

  property p_direct;
    O_MEM_VALID && !cur_map.remap |->
      O_MEM.addr == cur_req.addr && O_MEM.write == cur_req.write &&
      (!O_MEM.write || O_MEM.wdata == cur_req.wdata);
  endproperty
  a_direct: assert property (p_direct) else $error("direct access altered");

  property p_pos;
    O_MEM_VALID && cur_map.remap |-> cur_map.pos == cur_req.addr[6:2];
  endproperty
  a_pos: assert property (p_pos) else $error("bit position wrong");

  property p_bb_region;
    O_MEM_VALID && cur_map.remap |->
      O_MEM.addr[31:20] == (cur_req.addr[30] ? PERI_BB_BASE[31:20] : SRAM_BB_BASE[31:20]);
  endproperty
  a_bb_region: assert property (p_bb_region) else $error("outside bit-band window");

  property p_mem_hold;
    O_MEM_VALID && !I_MEM_READY |=> O_MEM_VALID && $stable(O_MEM);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("request dropped early");

  property p_lock_hold;
    rmw && !O_REQ_READY && !O_RSP_VALID |-> O_MEM.lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock fell inside rmw");

  property p_rd_no_write;
    O_MEM_VALID && cur_map.remap && !cur_req.write |-> !O_MEM.write && !O_MEM.lock;
  endproperty
  a_rd_no_write: assert property (p_rd_no_write) else $error("alias read wrote");

  property p_wr_rsp;
    state == S_WR_WAIT && I_MEM_RVALID |=> O_RSP_VALID && O_RSP.rdata == DATA_RESET && !O_MEM.lock;
  endproperty
  a_wr_rsp: assert property (p_wr_rsp) else $error("rmw end wrong");

  property p_err_fetch;
    O_RSP_VALID && O_RSP.err |-> cur_req.fetch && ((cur_req.addr - PERI_ALIAS_BASE) < ALIAS_SIZE);
  endproperty
  a_err_fetch: assert property (p_err_fetch) else $error("unexpected error");

  property p_rsp_pulse;
    O_RSP_VALID |=> !O_RSP_VALID && O_REQ_READY;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response not a pulse");

  property p_idle_quiet;
    O_REQ_READY |-> !O_MEM_VALID && !O_MEM.lock;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("bus busy while idle");

endmodule // bbar_bridge

/* core/bbar_pkg.sv */
// Constants, carrier types and helper functions of the bit-band alias remapper
package bbar_pkg;

  // ***************************************************************
  // Address map
  // ***************************************************************
  localparam logic [31:0] SRAM_BB_BASE    = 32'h2000_0000;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] PERI_BB_BASE    = 32'h4000_0000;
  localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
  localparam logic [31:0] ALIAS_SIZE      = 32'h0200_0000;
  localparam logic [31:0] BB_SIZE         = 32'h0010_0000;

  // Alias offset fields: byte offset times 32, bit number times 4
  localparam int ALIAS_BYTE_LSB = 5;
  localparam int ALIAS_BYTE_MSB = 24;
  localparam int ALIAS_BIT_LSB  = 2;
  localparam int ALIAS_BIT_MSB  = 4;

  // ***************************************************************
  // Access sizes and reset values
  // ***************************************************************
  localparam logic [1:0]  SIZE_BYTE  = 2'h0;
  localparam logic [1:0]  SIZE_HALF  = 2'h1;
  localparam logic [1:0]  SIZE_WORD  = 2'h2;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [31:0] ALIAS_ONE  = 32'h0000_0001;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    S_IDLE     = 3'h0,
    S_ISSUE    = 3'h1,
    S_WAIT     = 3'h3,
    S_WR_ISSUE = 3'h2,
    S_WR_WAIT  = 3'h6,
    S_RESP     = 3'h7
  } bbar_state_type;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic        fetch;
  } bbar_req_type;

  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } bbar_rsp_type;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic        lock;
  } bbar_mem_type;

  typedef struct packed {
    logic        remap;
    logic        err;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [4:0]  pos;
  } bbar_map_type;

  // ***************************************************************
  // Functions
  // ***************************************************************
  function automatic logic [31:0] bbar_alias_addr(input logic [31:0] base,
                                                  input logic [19:0] byte_off,
                                                  input logic [2:0]  bit_num);
    bbar_alias_addr = base + {7'h00, byte_off, 5'h00} + {27'h0, bit_num, 2'h0};
  endfunction

  function automatic logic [31:0] bbar_align(input logic [31:0] addr,
                                             input logic [1:0]  size);
    case (size)
      SIZE_WORD: bbar_align = {addr[31:2], 2'h0};
      SIZE_HALF: bbar_align = {addr[31:1], 1'h0};
      default:   bbar_align = addr;
    endcase
  endfunction

  function automatic logic [31:0] bbar_put_bit(input logic [31:0] word,
                                               input logic [4:0]  pos,
                                               input logic        value);
    logic [31:0] result;
    result      = word;
    result[pos] = value;
    bbar_put_bit = result;
  endfunction

endpackage

/* core/bbar_remap.sv */
// Address classifier that turns an alias address into bit-band address and bit position
`timescale 1ns/1ps
module bbar_remap (
  // Upstream request
  input  wire bbar_pkg::bbar_req_type i_req,
  // Decoded mapping
  output bbar_pkg::bbar_map_type      o_map
);
  import bbar_pkg::*;

  logic [31:0] off_sram;
  logic [31:0] off_peri;
  logic [31:0] off;
  logic [31:0] base;
  logic [31:0] tbyte;
  logic        in_sram;
  logic        in_peri;

  always_comb begin
    off_sram = i_req.addr - SRAM_ALIAS_BASE;
    off_peri = i_req.addr - PERI_ALIAS_BASE;
    in_sram  = off_sram < ALIAS_SIZE;
    in_peri  = off_peri < ALIAS_SIZE;
    off      = in_sram ? off_sram : off_peri;
    // Bit-band regions sit at the bottom of their memory regions
    base     = in_sram ? SRAM_BB_BASE : PERI_BB_BASE;
    // Twenty offset bits cover exactly the 1 MB bit-band window
    tbyte    = base + {12'h000, off[ALIAS_BYTE_MSB:ALIAS_BYTE_LSB]};
    o_map.remap = (in_sram && !i_req.fetch) || (in_peri && !i_req.fetch);
    o_map.err   = in_peri && i_req.fetch;
    o_map.size  = i_req.size;
    if (o_map.remap) begin
      o_map.addr = bbar_align(tbyte, i_req.size);
      // Lanes follow the byte address, least significant byte lowest
      o_map.pos  = {tbyte[1:0], off[ALIAS_BIT_MSB:ALIAS_BIT_LSB]};
    end else begin
      o_map.addr = i_req.addr;
      o_map.pos  = 5'h00;
    end
  end

endmodule // bbar_remap

/* verification/bbar_bridge_test.sv */
// Self-checking testbench of the bit-band alias bridge
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module bbar_bridge_test;
  import bbar_pkg::*;
  logic         I_CLK = 1'b0;
  logic         I_RST = 1'b1;
  logic         I_REQ_VALID = 1'b0;
  bbar_req_type I_REQ = '0;
  logic         O_REQ_READY, O_RSP_VALID, O_MEM_VALID, I_MEM_READY, I_MEM_RVALID;
  bbar_rsp_type O_RSP;
  bbar_mem_type O_MEM;
  logic [31:0]  I_MEM_RDATA;
  logic [31:0]  mirror [logic [31:0]];
  int           n_mismatch = 0;
  int           checks_done = 0;
  int           seed = 23871;

  always #12.5 I_CLK = ~I_CLK;

  bbar_bridge dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ),
    .O_REQ_READY(O_REQ_READY), .O_RSP_VALID(O_RSP_VALID), .O_RSP(O_RSP),
    .O_MEM_VALID(O_MEM_VALID), .O_MEM(O_MEM), .I_MEM_READY(I_MEM_READY),
    .I_MEM_RVALID(I_MEM_RVALID), .I_MEM_RDATA(I_MEM_RDATA));
  bbar_mem_model mem (.i_clk(I_CLK), .i_rst(I_RST), .i_mem_valid(O_MEM_VALID), .i_mem(O_MEM),
    .o_mem_ready(I_MEM_READY), .o_mem_rvalid(I_MEM_RVALID), .o_mem_rdata(I_MEM_RDATA));

  // ***************************************************************
  // Reference memory
  // ***************************************************************
  function automatic logic [31:0] mir(input logic [31:0] a);
    logic [31:0] k;
    k = {a[31:2], 2'h0};
    return mirror.exists(k) ? mirror[k] : ({k[15:0], ~k[15:0]} ^ 32'h5A3C_96E1);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, a, input logic [1:0] s,
                                        input logic [31:0] d);
    logic [31:0] m;
    m = (s == SIZE_WORD) ? 32'hFFFF_FFFF : (s == SIZE_HALF) ?
        (32'h0000_FFFF << {a[1], 4'h0}) : (32'h0000_00FF << {a[1:0], 3'h0});
    return (o & ~m) | (d & m);
  endfunction

  // ***************************************************************
  // One upstream transfer with downstream monitoring
  // ***************************************************************
  task automatic xfer(input logic [31:0] a, input logic w, input logic [1:0] sz,
                      input logic [31:0] wd, input logic f);
    logic         peri, hit;
    logic [31:0]  bb, ea, word, ewd;
    logic [4:0]   pos;
    bbar_mem_type acc [2];
    bbar_rsp_type rsp;
    int           nacc, k;
    peri = (a >= PERI_ALIAS_BASE) && (a < PERI_ALIAS_BASE + ALIAS_SIZE);
    hit  = !f && (peri || ((a >= SRAM_ALIAS_BASE) && (a < SRAM_ALIAS_BASE + ALIAS_SIZE)));
    bb   = (peri ? PERI_BB_BASE : SRAM_BB_BASE) + {12'h000, a[24:5]};
    pos  = {bb[1:0], a[4:2]};
    ea   = (sz == SIZE_WORD) ? {bb[31:2], 2'h0} : (sz == SIZE_HALF) ? {bb[31:1], 1'h0} : bb;
    word = mir(bb);
    acc[0] = '0;
    acc[1] = '0;
    nacc = 0;
    rsp = '0;
    @(posedge I_CLK);
    I_REQ_VALID <= 1'b1;
    I_REQ <= '{addr: a, write: w, size: sz, wdata: wd, fetch: f};
    do @(posedge I_CLK); while (!O_REQ_READY);
    I_REQ_VALID <= 1'b0;
    for (k = 1; k < 100; k++) begin
      @(posedge I_CLK);
      if (O_MEM_VALID && I_MEM_READY) begin
        if (nacc < 2) acc[nacc] = O_MEM;
        nacc++;
      end
      if (O_RSP_VALID) break;
    end
    rsp = O_RSP;
    if (k == 100) `CHK("response", 1, 0)
    if (!(peri && f)) `CHK("rsp err", 1'b0, rsp.err)
    if (peri && f) begin
      `CHK("fetch err", 1'b1, rsp.err)
      `CHK("fetch accesses", 0, nacc)
      `CHK("fetch latency", 1, k)
      `CHK("fetch rdata", 32'h0, rsp.rdata)
    end else if (hit) begin
      `CHK("alias addr", ea, acc[0].addr)
      `CHK("alias size", sz, acc[0].size)
      `CHK("read half", 1'b0, acc[0].write)
      `CHK("read lock", w, acc[0].lock)
      if (w) begin
        ewd = word;
        ewd[pos] = wd[0];
        `CHK("rmw count", 2, nacc)
        `CHK("rmw wdata", ewd, acc[1].wdata)
        `CHK("rmw addr", ea, acc[1].addr)
        `CHK("rmw write", 1'b1, acc[1].write)
        `CHK("rmw lock", 1'b1, acc[1].lock)
        `CHK("wr rdata", 32'h0, rsp.rdata)
        mirror[{bb[31:2], 2'h0}] = ewd;
      end else begin
        `CHK("read count", 1, nacc)
        `CHK("alias rdata", {31'h0, word[pos]}, rsp.rdata)
      end
    end else begin
      `CHK("direct count", 1, nacc)
      `CHK("direct addr", a, acc[0].addr)
      `CHK("direct size", sz, acc[0].size)
      `CHK("direct lock", 1'b0, acc[0].lock)
      `CHK("direct write", w, acc[0].write)
      if (w) `CHK("direct wdata", wd, acc[0].wdata)
      if (w) mirror[{a[31:2], 2'h0}] = merge(mir(a), a, sz, wd);
      else `CHK("direct rdata", mir(a), rsp.rdata)
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ***************************************************************
  // Stimulus
  // ***************************************************************
  initial begin
    repeat (20000) @(posedge I_CLK);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    logic [31:0] r, a;
    logic [1:0]  sz;
    repeat (10) @(posedge I_CLK);
    I_RST <= 1'b0;
    // Window corners, including upper bits of write data that must not matter
    xfer(32'h23FF_FFE0, 1'b1, SIZE_WORD, 32'h0000_00FF, 1'b0);
    xfer(32'h23FF_FFFC, 1'b1, SIZE_WORD, 32'h0000_000E, 1'b0);
    xfer(32'h23FF_FFE0, 1'b0, SIZE_WORD, 32'h0, 1'b0);
    xfer(32'h23FF_FFFC, 1'b0, SIZE_BYTE, 32'h0, 1'b0);
    xfer(32'h2200_0000, 1'b1, SIZE_BYTE, 32'hFFFF_FFFF, 1'b0);
    xfer(32'h2200_001F, 1'b1, SIZE_HALF, 32'h0000_0001, 1'b0);
    xfer(32'h2000_0000, 1'b0, SIZE_WORD, 32'h0, 1'b0);
    xfer(32'h43FF_FFFC, 1'b1, SIZE_WORD, 32'hFFFF_FFFE, 1'b0);
    xfer(32'h400F_FFFC, 1'b0, SIZE_WORD, 32'h0, 1'b0);
    xfer(32'h4200_0000, 1'b0, SIZE_WORD, 32'h0, 1'b1);
    xfer(32'h43FF_FFFC, 1'b0, SIZE_WORD, 32'h0, 1'b1);
    xfer(32'h2200_0020, 1'b0, SIZE_WORD, 32'h0, 1'b1);
    // Random mix over a small window so alias and direct traffic overlap
    repeat (200) begin
      r  = $random(seed);
      sz = (r[10:9] == 2'h3) ? SIZE_WORD : r[10:9];
      case (r[1:0])
        2'h0: a = SRAM_ALIAS_BASE + {r[5:2], 5'h00} + {r[8:6], 2'h0} + r[16:15];
        2'h1: a = PERI_ALIAS_BASE + {r[5:2], 5'h00} + {r[8:6], 2'h0} + r[16:15];
        2'h2: a = SRAM_BB_BASE + r[5:2];
        default: a = PERI_BB_BASE + r[5:2];
      endcase
      if (!r[1]) a = a;
      else if (sz == SIZE_WORD) a[1:0] = 2'h0;
      else if (sz == SIZE_HALF) a[0] = 1'b0;
      xfer(a, r[11], sz, $random(seed), (r[14:12] == 3'h0) && !r[11]);
    end
    give_verdict;
  end
endmodule // bbar_bridge_test

/* verification/bbar_mem_model.sv */
// Behavioural memory on the downstream bus with random accept and completion delays
`timescale 1ns/1ps
module bbar_mem_model (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Request from the bridge
  input  wire logic                   i_mem_valid,
  input  wire bbar_pkg::bbar_mem_type i_mem,
  // Answer to the bridge
  output logic                        o_mem_ready,
  output logic                        o_mem_rvalid,
  output logic [31:0]                 o_mem_rdata
);
  import bbar_pkg::*;
  logic [31:0]  mem_arr [logic [31:0]];
  bbar_mem_type held;
  logic         pend = 1'b0;
  int           wait_cnt = 0;
  int           seed = 5113;
  logic [31:0]  k;
  logic [31:0]  old;
  logic [31:0]  msk;

  initial o_mem_ready = 1'b0;
  initial o_mem_rvalid = 1'b0;
  initial o_mem_rdata = 32'h0000_0000;

  // Unwritten words read back an address pattern, never a constant
  function automatic logic [31:0] init_word(input logic [31:0] a);
    return {a[15:0], ~a[15:0]} ^ 32'h5A3C_96E1;
  endfunction

  always @(posedge i_clk) begin
    o_mem_rvalid <= 1'b0;
    // Idle data lines toggle so a stale value is never mistaken for an answer
    o_mem_rdata  <= ~o_mem_rdata;
    if (i_rst) begin
      o_mem_ready <= 1'b0;
      pend        <= 1'b0;
    end else if (pend) begin
      if (wait_cnt == 0) begin
        pend         <= 1'b0;
        o_mem_rvalid <= 1'b1;
        k   = {held.addr[31:2], 2'h0};
        old = mem_arr.exists(k) ? mem_arr[k] : init_word(k);
        msk = (held.size == SIZE_WORD) ? 32'hFFFF_FFFF :
              (held.size == SIZE_HALF) ? (32'h0000_FFFF << {held.addr[1], 4'h0}) :
              (32'h0000_00FF << {held.addr[1:0], 3'h0});
        if (held.write) mem_arr[k] = (old & ~msk) | (held.wdata & msk);
        else o_mem_rdata <= old;
      end else begin
        wait_cnt <= wait_cnt - 1;
      end
    end else if (i_mem_valid && o_mem_ready) begin
      held        <= i_mem;
      pend        <= 1'b1;
      o_mem_ready <= 1'b0;
      wait_cnt    <= ($random(seed) & 3);
    end else begin
      o_mem_ready <= i_mem_valid && (($random(seed) & 1) != 0);
    end
  end
endmodule // bbar_mem_model
